//--- verilog/rpvm_params.svh
// Functional notes
// R1: Separate register copy per port, chosen by select.
// R2: Frame line total readable as two bytes.
// R3: Line total frozen until read when enabled.
// R4: High byte read latches matching low byte.
// R5: Line width readable, low byte resets zero.
// R6: Recorded width is last line of frame.
// R7: Line width frozen until read when enabled.
// R8: Width high byte read latches low byte.
// R9: Capture frequency only beyond hysteresis band.
// R10: Settle time selectable 40/80/320/1280 us.
// R11: Clock absent flag when below floor.
// R12: Mailbox byte, read/write, resets to zero.
// R13: Line total high byte at 0x73.
// R14: Updates resume after frozen value is read.
// R15: Absent flag clears at or above floor.
`ifndef RPVM_PARAMS_SVH
`define RPVM_PARAMS_SVH

// ==========================================================
// Register offsets
`define RPVM_ADDR_PORT_SEL   8'h4C
`define RPVM_ADDR_LINES_HI   8'h73
`define RPVM_ADDR_LINES_LO   8'h74
`define RPVM_ADDR_WIDTH_HI   8'h75
`define RPVM_ADDR_WIDTH_LO   8'h76
`define RPVM_ADDR_FREQ_CFG   8'h77
`define RPVM_ADDR_MAILBOX    8'h78

// ==========================================================
// Fields and reset values
`define RPVM_PSEL_MSB        1
`define RPVM_PSEL_LSB        0
`define RPVM_HYST_MSB        7
`define RPVM_HYST_LSB        6
`define RPVM_SETTLE_MSB      5
`define RPVM_SETTLE_LSB      4
`define RPVM_FLOOR_MSB       3
`define RPVM_FLOOR_LSB       0
`define RPVM_PSEL_RESET      8'h00
`define RPVM_FREQ_CFG_RESET  8'hC5
`define RPVM_MAILBOX_RESET   8'h00
`define RPVM_MEAS_RESET      16'h0000
`define RPVM_NUM_PORTS       4

// ==========================================================
// Timing
`define RPVM_CLK_PERIOD_NS   40
`define RPVM_SETTLE0_NS      40000
`define RPVM_SETTLE1_NS      80000
`define RPVM_SETTLE2_NS      320000
`define RPVM_SETTLE3_NS      1280000
`define RPVM_SETTLE0_CYC     ((`RPVM_SETTLE0_NS + `RPVM_CLK_PERIOD_NS - 1) / `RPVM_CLK_PERIOD_NS)
`define RPVM_SETTLE1_CYC     ((`RPVM_SETTLE1_NS + `RPVM_CLK_PERIOD_NS - 1) / `RPVM_CLK_PERIOD_NS)
`define RPVM_SETTLE2_CYC     ((`RPVM_SETTLE2_NS + `RPVM_CLK_PERIOD_NS - 1) / `RPVM_CLK_PERIOD_NS)
`define RPVM_SETTLE3_CYC     ((`RPVM_SETTLE3_NS + `RPVM_CLK_PERIOD_NS - 1) / `RPVM_CLK_PERIOD_NS)

`endif

//--- verilog/rpvm_pkg.sv
package rpvm_pkg;
    typedef logic [7:0]  rpvm_byte_type;
    typedef logic [15:0] rpvm_word_type;
    typedef logic [1:0]  rpvm_port_type;
    typedef enum logic { RPVM_SETTLING, RPVM_STABLE } rpvm_fstate_type;
endpackage

//--- verilog/rpvm_if.sv
`timescale 1ns/1ps
interface rpvm_meas_if;
    import rpvm_pkg::*;
    logic          sample_valid;
    rpvm_word_type sample;
    logic          freeze_en;
    logic          rd_hi;
    logic          rd_lo;
    rpvm_word_type value;
    rpvm_byte_type lo_shadow;
    logic          unread;
    modport producer (output sample_valid, sample, freeze_en, rd_hi, rd_lo, input value, lo_shadow, unread);
    modport keeper   (input sample_valid, sample, freeze_en, rd_hi, rd_lo, output value, lo_shadow, unread);
endinterface

interface rpvm_freq_if;
    import rpvm_pkg::*;
    logic          meas_valid;
    rpvm_byte_type meas_mhz;
    logic [1:0]    hyst;
    logic [1:0]    settle_sel;
    logic [3:0]    floor_mhz;
    rpvm_byte_type held_mhz;
    logic          stable;
    logic          absent;
    modport producer (output meas_valid, meas_mhz, hyst, settle_sel, floor_mhz, input held_mhz, stable, absent);
    modport keeper   (input meas_valid, meas_mhz, hyst, settle_sel, floor_mhz, output held_mhz, stable, absent);
endinterface

//--- verilog/rpvm_meas_latch.sv
`timescale 1ns/1ps
`include "rpvm_params.svh"
module rpvm_meas_latch (
    input wire logic     clk,
    input wire logic     rst_n,
    rpvm_meas_if.keeper  m
);
    import rpvm_pkg::*;

    rpvm_word_type value_ff;
    rpvm_word_type nxt_value;
    rpvm_byte_type lo_shadow_ff;
    rpvm_byte_type nxt_lo_shadow;
    logic          unread_ff;
    logic          nxt_unread;

    // ==========================================================
    // Freeze and low byte latch
    always_comb begin
        nxt_value     = value_ff;
        nxt_lo_shadow = lo_shadow_ff;
        nxt_unread    = unread_ff;
        if (m.rd_lo) begin
            nxt_unread = 1'b0; // R14
        end
        if (m.rd_hi) begin
            nxt_lo_shadow = value_ff[7:0]; // R4 R8
        end
        // A new sample in the cycle of the completing read still lands.
        if (m.sample_valid && (!m.freeze_en || !unread_ff || m.rd_lo)) begin
            nxt_value  = m.sample; // R3 R7 R14
            nxt_unread = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_ff     <= `RPVM_MEAS_RESET;
            lo_shadow_ff <= 8'h00;
            unread_ff    <= 1'b0;
        end else begin
            value_ff     <= nxt_value;
            lo_shadow_ff <= nxt_lo_shadow;
            unread_ff    <= nxt_unread;
        end
    end

    assign m.value     = value_ff;
    assign m.lo_shadow = lo_shadow_ff;
    assign m.unread    = unread_ff;

    // ==========================================================
    // Checks
    a_frozen_hold: assert property (@(posedge clk) disable iff (!rst_n) // R3
        m.freeze_en && unread_ff && !m.rd_lo |=> $stable(value_ff))
        else $error("frozen value changed before read");
    a_hi_latch: assert property (@(posedge clk) disable iff (!rst_n) // R4
        m.rd_hi |=> lo_shadow_ff == $past(value_ff[7:0]))
        else $error("low byte not latched on high read");
    a_resume_update: assert property (@(posedge clk) disable iff (!rst_n) // R14
        m.sample_valid && (!unread_ff || !m.freeze_en) |=> value_ff == $past(m.sample) && unread_ff)
        else $error("sample not taken when free");
endmodule

//--- verilog/rpvm_freq_det.sv
`timescale 1ns/1ps
`include "rpvm_params.svh"
module rpvm_freq_det #(
    parameter logic [15:0] SETTLE2_CYC = 16'd8000,
    parameter logic [15:0] SETTLE3_CYC = 16'd32000
) (
    input wire logic     clk,
    input wire logic     rst_n,
    rpvm_freq_if.keeper  f
);
    import rpvm_pkg::*;

    rpvm_fstate_type state_ff;
    rpvm_fstate_type nxt_state;
    rpvm_byte_type   held_ff;
    rpvm_byte_type   nxt_held;
    logic [15:0]     cnt_ff;
    logic [15:0]     nxt_cnt;
    logic            absent_ff;
    logic            nxt_absent;
    rpvm_byte_type   diff;
    logic [15:0]     limit;
    logic            capture;

    // ==========================================================
    // Hysteresis capture, settle timer and floor compare
    always_comb begin
        diff    = (f.meas_mhz > held_ff) ? (f.meas_mhz - held_ff) : (held_ff - f.meas_mhz);
        capture = f.meas_valid && (diff > {6'h00, f.hyst}); // R9
        case (f.settle_sel) // R10
            2'h0:    limit = 16'(`RPVM_SETTLE0_CYC);
            2'h1:    limit = 16'(`RPVM_SETTLE1_CYC);
            2'h2:    limit = SETTLE2_CYC;
            default: limit = SETTLE3_CYC;
        endcase
        nxt_state  = state_ff;
        nxt_held   = held_ff;
        nxt_cnt    = cnt_ff;
        nxt_absent = absent_ff;
        if (f.meas_valid) begin
            nxt_absent = (f.meas_mhz < {4'h0, f.floor_mhz}); // R11 R15
        end
        if (capture) begin
            nxt_held  = f.meas_mhz;
            nxt_cnt   = 16'h0000;
            nxt_state = RPVM_SETTLING;
        end else begin
            case (state_ff)
                RPVM_SETTLING: begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    if (nxt_cnt >= limit) begin
                        nxt_state = RPVM_STABLE; // R10
                    end
                end
                RPVM_STABLE: begin
                    nxt_cnt = cnt_ff;
                end
                default: nxt_state = RPVM_SETTLING;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= RPVM_SETTLING;
            held_ff   <= 8'h00;
            cnt_ff    <= 16'h0000;
            absent_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            held_ff   <= nxt_held;
            cnt_ff    <= nxt_cnt;
            absent_ff <= nxt_absent;
        end
    end

    assign f.held_mhz = held_ff;
    assign f.stable   = (state_ff == RPVM_STABLE);
    assign f.absent   = absent_ff;

    // ==========================================================
    // Checks
    a_hyst_capture: assert property (@(posedge clk) disable iff (!rst_n) // R9
        capture |=> held_ff == $past(f.meas_mhz) && state_ff == RPVM_SETTLING)
        else $error("out of band measurement not captured");
    a_hyst_ignore: assert property (@(posedge clk) disable iff (!rst_n) // R9
        f.meas_valid && !capture |=> held_ff == $past(held_ff))
        else $error("in band measurement captured");
    a_absent_set: assert property (@(posedge clk) disable iff (!rst_n) // R11
        f.meas_valid && (f.meas_mhz < {4'h0, f.floor_mhz}) |=> absent_ff)
        else $error("absent flag not set below floor");
    a_absent_clear: assert property (@(posedge clk) disable iff (!rst_n) // R15
        f.meas_valid && (f.meas_mhz >= {4'h0, f.floor_mhz}) |=> !absent_ff)
        else $error("absent flag not cleared at floor");
    a_settle_40us: assert property (@(posedge clk) disable iff (!rst_n) // R10
        capture && f.settle_sel == 2'h0 ##1 (!f.meas_valid && f.settle_sel == 2'h0) [*8] |-> state_ff == RPVM_SETTLING)
        else $error("stable declared too early");
endmodule

//--- verilog/rpvm_top.sv
`timescale 1ns/1ps
`include "rpvm_params.svh"
module rpvm_top #(
    parameter logic [15:0] SETTLE2_CYC = 16'(`RPVM_SETTLE2_CYC),
    parameter logic [15:0] SETTLE3_CYC = 16'(`RPVM_SETTLE3_CYC)
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_rd,
    output logic [7:0]                         reg_rdata,
    input  wire logic [3:0]                    frame_done,
    input  wire rpvm_pkg::rpvm_word_type [3:0] frame_lines,
    input  wire logic [3:0]                    line_done,
    input  wire rpvm_pkg::rpvm_word_type [3:0] line_width,
    input  wire logic [3:0]                    line_total_change_irq_enable,
    input  wire logic [3:0]                    line_width_change_irq_enable,
    input  wire logic [3:0]                    freq_meas_valid,
    input  wire rpvm_pkg::rpvm_byte_type [3:0] freq_meas_mhz,
    output logic [3:0]                         serial_clock_absent_flag,
    output logic [3:0]                         freq_stable
);
    import rpvm_pkg::*;

    // ==========================================================
    // Host-visible state
    rpvm_byte_type       port_sel_ff;
    rpvm_byte_type       nxt_port_sel;
    rpvm_byte_type [3:0] freq_cfg_ff;
    rpvm_byte_type [3:0] nxt_freq_cfg;
    rpvm_byte_type [3:0] mailbox_ff;
    rpvm_byte_type [3:0] nxt_mailbox;
    rpvm_byte_type       rdata_ff;
    rpvm_byte_type       nxt_rdata;
    rpvm_word_type [3:0] width_work_ff;
    rpvm_word_type [3:0] nxt_width_work;

    rpvm_port_type       sel;
    rpvm_word_type [3:0] lines_val;
    rpvm_byte_type [3:0] lines_lo;
    rpvm_word_type [3:0] width_val;
    rpvm_byte_type [3:0] width_lo;
    logic [3:0]          absent_w;
    logic [3:0]          stable_w;
    logic [3:0]          hit_port;

    assign sel = port_sel_ff[`RPVM_PSEL_MSB:`RPVM_PSEL_LSB];

    // ==========================================================
    // Per-port measurement and detector instances
    genvar p;
    generate
        for (p = 0; p < `RPVM_NUM_PORTS; p = p + 1) begin : g_port
            rpvm_meas_if lines_if ();
            rpvm_meas_if width_if ();
            rpvm_freq_if freq_if ();

            // Only the selected port sees the access.
            assign hit_port[p] = (sel == 2'(p)); // R1

            assign lines_if.sample_valid = frame_done[p]; // R2
            assign lines_if.sample       = frame_lines[p];
            assign lines_if.freeze_en    = line_total_change_irq_enable[p];
            assign lines_if.rd_hi        = reg_rd && hit_port[p] && (reg_addr == `RPVM_ADDR_LINES_HI); // R4 R13
            assign lines_if.rd_lo        = reg_rd && hit_port[p] && (reg_addr == `RPVM_ADDR_LINES_LO);

            // The width published at frame end is the last line seen in that frame.
            assign width_if.sample_valid = frame_done[p]; // R6
            assign width_if.sample       = line_done[p] ? line_width[p] : width_work_ff[p];
            assign width_if.freeze_en    = line_width_change_irq_enable[p];
            assign width_if.rd_hi        = reg_rd && hit_port[p] && (reg_addr == `RPVM_ADDR_WIDTH_HI); // R8
            assign width_if.rd_lo        = reg_rd && hit_port[p] && (reg_addr == `RPVM_ADDR_WIDTH_LO);

            assign freq_if.meas_valid    = freq_meas_valid[p];
            assign freq_if.meas_mhz      = freq_meas_mhz[p];
            assign freq_if.hyst          = freq_cfg_ff[p][`RPVM_HYST_MSB:`RPVM_HYST_LSB];
            assign freq_if.settle_sel    = freq_cfg_ff[p][`RPVM_SETTLE_MSB:`RPVM_SETTLE_LSB];
            assign freq_if.floor_mhz     = freq_cfg_ff[p][`RPVM_FLOOR_MSB:`RPVM_FLOOR_LSB];

            assign lines_val[p] = lines_if.value;
            assign lines_lo[p]  = lines_if.lo_shadow;
            assign width_val[p] = width_if.value;
            assign width_lo[p]  = width_if.lo_shadow;
            assign absent_w[p]  = freq_if.absent;
            assign stable_w[p]  = freq_if.stable;

            rpvm_meas_latch u_lines (
                .clk   (clk),
                .rst_n (rst_n),
                .m     (lines_if.keeper)
            );

            rpvm_meas_latch u_width (
                .clk   (clk),
                .rst_n (rst_n),
                .m     (width_if.keeper)
            );

            rpvm_freq_det #(
                .SETTLE2_CYC (SETTLE2_CYC),
                .SETTLE3_CYC (SETTLE3_CYC)
            ) u_freq (
                .clk   (clk),
                .rst_n (rst_n),
                .f     (freq_if.keeper)
            );
        end
    endgenerate

    // ==========================================================
    // Line width working register
    always_comb begin
        nxt_width_work = width_work_ff;
        for (int i = 0; i < `RPVM_NUM_PORTS; i++) begin
            if (line_done[i]) begin
                nxt_width_work[i] = line_width[i]; // R6
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            width_work_ff <= {`RPVM_NUM_PORTS{`RPVM_MEAS_RESET}};
        end else begin
            width_work_ff <= nxt_width_work;
        end
    end

    // ==========================================================
    // Register writes
    always_comb begin
        nxt_port_sel = port_sel_ff;
        nxt_freq_cfg = freq_cfg_ff;
        nxt_mailbox  = mailbox_ff;
        if (reg_wr) begin
            case (reg_addr)
                `RPVM_ADDR_PORT_SEL: begin
                    nxt_port_sel = {6'h00, reg_wdata[`RPVM_PSEL_MSB:`RPVM_PSEL_LSB]}; // R1
                end
                `RPVM_ADDR_FREQ_CFG: begin
                    nxt_freq_cfg[sel] = reg_wdata; // R1 R9 R10 R11
                end
                `RPVM_ADDR_MAILBOX: begin
                    nxt_mailbox[sel] = reg_wdata; // R12
                end
                default: begin
                    nxt_port_sel = port_sel_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_sel_ff <= `RPVM_PSEL_RESET;
            freq_cfg_ff <= {`RPVM_NUM_PORTS{`RPVM_FREQ_CFG_RESET}};
            mailbox_ff  <= {`RPVM_NUM_PORTS{`RPVM_MAILBOX_RESET}};
        end else begin
            port_sel_ff <= nxt_port_sel;
            freq_cfg_ff <= nxt_freq_cfg;
            mailbox_ff  <= nxt_mailbox;
        end
    end

    // ==========================================================
    // Register reads
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            case (reg_addr)
                `RPVM_ADDR_PORT_SEL: nxt_rdata = port_sel_ff;
                `RPVM_ADDR_LINES_HI: nxt_rdata = lines_val[sel][15:8]; // R2 R13
                `RPVM_ADDR_LINES_LO: nxt_rdata = lines_lo[sel];        // R2 R4
                `RPVM_ADDR_WIDTH_HI: nxt_rdata = width_val[sel][15:8]; // R5
                `RPVM_ADDR_WIDTH_LO: nxt_rdata = width_lo[sel];        // R5 R8
                `RPVM_ADDR_FREQ_CFG: nxt_rdata = freq_cfg_ff[sel];
                `RPVM_ADDR_MAILBOX:  nxt_rdata = mailbox_ff[sel];      // R12
                default:             nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff                 <= 8'h00;
            serial_clock_absent_flag <= 4'h0;
            freq_stable              <= 4'h0;
        end else begin
            rdata_ff                 <= nxt_rdata;
            serial_clock_absent_flag <= absent_w; // R11 R15
            freq_stable              <= stable_w; // R10
        end
    end

    assign reg_rdata = rdata_ff;

    // ==========================================================
    // Checks
    a_mailbox_write: assert property (@(posedge clk) disable iff (!rst_n) // R12
        reg_wr && reg_addr == `RPVM_ADDR_MAILBOX ##1 !reg_wr
        ##1 reg_rd && !reg_wr && reg_addr == `RPVM_ADDR_MAILBOX
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("mailbox does not read back written byte");
    a_port_isolated: assert property (@(posedge clk) disable iff (!rst_n) // R1
        reg_wr && reg_addr == `RPVM_ADDR_MAILBOX |=> mailbox_ff[$past(sel) + 2'h1] == $past(mailbox_ff[sel + 2'h1]))
        else $error("write reached an unselected port");
    a_lines_pair: assert property (@(posedge clk) disable iff (!rst_n) // R4
        reg_rd && reg_addr == `RPVM_ADDR_LINES_HI && !reg_wr ##1 !reg_rd && !reg_wr
        ##1 reg_rd && reg_addr == `RPVM_ADDR_LINES_LO && !reg_wr && $stable(sel)
        |=> reg_rdata == $past(lines_val[sel][7:0], 3))
        else $error("line total bytes not coherent");
    a_width_pair: assert property (@(posedge clk) disable iff (!rst_n) // R8
        reg_rd && reg_addr == `RPVM_ADDR_WIDTH_HI && !reg_wr ##1 !reg_rd && !reg_wr
        ##1 reg_rd && reg_addr == `RPVM_ADDR_WIDTH_LO && !reg_wr && $stable(sel)
        |=> reg_rdata == $past(width_val[sel][7:0], 3))
        else $error("line width bytes not coherent");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && !(reg_addr inside {`RPVM_ADDR_PORT_SEL, [`RPVM_ADDR_LINES_HI:`RPVM_ADDR_MAILBOX]}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_width_last: assert property (@(posedge clk) disable iff (!rst_n) // R6
        frame_done[1] && !line_done[1] && (!line_width_change_irq_enable[1] || !g_port[1].width_if.unread)
        |=> width_val[1] == $past(width_work_ff[1]))
        else $error("recorded width is not last line");
    a_cfg_reset: assert property (@(posedge clk) $rose(rst_n) |-> freq_cfg_ff[0] == `RPVM_FREQ_CFG_RESET) // R9
        else $error("frequency config reset value wrong");
endmodule

//--- verif/rpvm_host.sv
`timescale 1ns/1ps
`include "rpvm_params.svh"
module rpvm_host (
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // Write data is inverted once the strobe drops so stale data never looks valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic sel(input logic [1:0] p);
        wr(`RPVM_ADDR_PORT_SEL, {6'h00, p});
    endtask
endmodule

//--- verif/rx_port_video_monitor_regs_tb.sv
`timescale 1ns/1ps
`include "rpvm_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module rx_port_video_monitor_regs_tb;
    import rpvm_pkg::*;
    localparam int S0 = 1000;
    localparam int S1 = 2000;
    localparam int S2 = 20;
    localparam int S3 = 40;
    logic                clk, rst_n, reg_wr, reg_rd;
    logic [7:0]          reg_addr, reg_wdata, reg_rdata;
    logic [3:0]          frame_done, line_done, lt_en, lw_en, fv, absent, stable;
    rpvm_word_type [3:0] frame_lines, line_width;
    rpvm_byte_type [3:0] fmhz;
    rpvm_byte_type       b;
    int                  n_fail, n_checks;
    rpvm_byte_type       ra[7] = '{8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h78, 8'h10};
    rpvm_byte_type       re[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC5, 8'h00, 8'h00};

    rpvm_top #(.SETTLE2_CYC(16'd20), .SETTLE3_CYC(16'd40)) u_rpvm_top (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_done(frame_done), .frame_lines(frame_lines),
        .line_done(line_done), .line_width(line_width), .line_total_change_irq_enable(lt_en),
        .line_width_change_irq_enable(lw_en), .freq_meas_valid(fv), .freq_meas_mhz(fmhz),
        .serial_clock_absent_flag(absent), .freq_stable(stable));
    rpvm_host u_rpvm_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk_rd(input rpvm_byte_type a, input rpvm_byte_type e);
        u_rpvm_host.rd(a, b);
        `CHK(b, e)
    endtask
    task automatic frame(input int p, input rpvm_word_type n);
        @(posedge clk);
        frame_done[p] <= 1'b1;
        frame_lines[p] <= n;
        @(posedge clk);
        frame_done[p] <= 1'b0;
        frame_lines[p] <= ~n;
    endtask
    task automatic line(input int p, input rpvm_word_type w);
        @(posedge clk);
        line_done[p] <= 1'b1;
        line_width[p] <= w;
        @(posedge clk);
        line_done[p] <= 1'b0;
        line_width[p] <= ~w;
    endtask
    task automatic meas(input int p, input rpvm_byte_type m);
        @(posedge clk);
        fv[p] <= 1'b1;
        fmhz[p] <= m;
        @(posedge clk);
        fv[p] <= 1'b0;
        fmhz[p] <= ~m;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_reset();
        #1;
        `CHK(stable, 4'h0)
        `CHK(absent, 4'h0)
        for (int i = 0; i < 7; i++) chk_rd(ra[i], re[i]);
        $display("test reset done");
    endtask
    task automatic t_mailbox();
        u_rpvm_host.wr(8'h4C, 8'hFE);
        chk_rd(8'h4C, 8'h02);
        for (int p = 0; p < 4; p++) begin
            u_rpvm_host.sel(p[1:0]);
            u_rpvm_host.wr(8'h78, 8'hA0 + p[7:0]);
            chk_rd(8'h78, 8'hA0 + p[7:0]);
            u_rpvm_host.wr(8'h73, 8'hFF);
        end
        for (int p = 0; p < 4; p++) begin
            u_rpvm_host.sel(p[1:0]);
            chk_rd(8'h78, 8'hA0 + p[7:0]);
            chk_rd(8'h73, 8'h00);
        end
        $display("test mailbox done");
    endtask
    task automatic t_measure();
        u_rpvm_host.sel(2'd1);
        line(1, 16'h1111);
        line(1, 16'h2345);
        frame(1, 16'h0438);
        chk_rd(8'h73, 8'h04);
        line(1, 16'h7788);
        frame(1, 16'h0999);
        chk_rd(8'h74, 8'h38);
        chk_rd(8'h75, 8'h77);
        line(1, 16'h0102);
        frame(1, 16'h0999);
        chk_rd(8'h76, 8'h88);
        $display("test measure done");
    endtask
    task automatic t_freeze();
        @(posedge clk);
        lt_en[3] <= 1'b1;
        lw_en[3] <= 1'b1;
        u_rpvm_host.sel(2'd3);
        line(3, 16'h0AAA);
        frame(3, 16'h0101);
        line(3, 16'h0BBB);
        frame(3, 16'h0202);
        chk_rd(8'h73, 8'h01);
        chk_rd(8'h74, 8'h01);
        chk_rd(8'h75, 8'h0A);
        chk_rd(8'h76, 8'hAA);
        line(3, 16'h0CCC);
        frame(3, 16'h0303);
        chk_rd(8'h73, 8'h03);
        chk_rd(8'h74, 8'h03);
        chk_rd(8'h75, 8'h0C);
        chk_rd(8'h76, 8'hCC);
        $display("test freeze done");
    endtask
    task automatic settle(input int n);
        repeat (n - 1) @(posedge clk);
        #1;
        `CHK(stable[2], 1'b0)
        @(posedge clk);
        #1;
        `CHK(stable[2], 1'b1)
    endtask
    task automatic recap(input rpvm_byte_type m, input int n);
        meas(2, m);
        @(posedge clk);
        #1;
        `CHK(absent[2], 1'b0)
        settle(n);
    endtask
    task automatic t_freq();
        u_rpvm_host.sel(2'd2);
        u_rpvm_host.wr(8'h77, 8'h65);
        chk_rd(8'h77, 8'h65);
        meas(2, 8'h02);
        @(posedge clk);
        #1;
        `CHK(absent[2], 1'b1)
        recap(8'h05, S2);
        meas(2, 8'h06);
        repeat (3) @(posedge clk);
        #1;
        `CHK(stable[2], 1'b1)
        meas(2, 8'h08);
        repeat (3) @(posedge clk);
        #1;
        `CHK(stable[2], 1'b0)
        u_rpvm_host.wr(8'h77, 8'h75);
        recap(8'h0C, S3);
        u_rpvm_host.wr(8'h77, 8'h55);
        recap(8'h10, S1);
        u_rpvm_host.wr(8'h77, 8'h45);
        recap(8'h14, S0);
        $display("test freq done");
    endtask
    initial begin
        rst_n = 1'b0;
        {frame_done, line_done, lt_en, lw_en, fv} = '0;
        frame_lines = '0;
        line_width = '0;
        fmhz = '0;
        n_fail = 0;
        n_checks = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_mailbox();
        t_measure();
        t_freeze();
        t_freq();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
